// File: hw/serial_port_pkg.sv
// Constants for the buffered serial port pin block.
// Assumes a 100 MHz system clock and AXI4-Lite register access.
package serial_port_pkg;
	localparam int           WORD_BITS    = 16;
	localparam logic [4:0]   WORD_LAST    = 5'h0f;
	localparam logic [31:0]  OFS_CONTROL  = 32'h0000_0000;
	localparam logic [31:0]  OFS_STATUS   = 32'h0000_0004;
	localparam logic [31:0]  OFS_TXDATA   = 32'h0000_0008;
	localparam logic [31:0]  OFS_RXDATA   = 32'h0000_000c;
	localparam logic [31:0]  OFS_CLKDIV   = 32'h0000_0010;
	// Control fields
	localparam int           CTL_RXCLK_OUT = 0;
	localparam int           CTL_RXFS_OUT  = 1;
	localparam int           CTL_TXCLK_OUT = 2;
	localparam int           CTL_TXFS_OUT  = 3;
	localparam logic [3:0]   CTL_RESET     = 4'h0;
	localparam logic [7:0]   CLKDIV_RESET  = 8'h04;
	localparam logic [1:0]   RESP_OKAY     = 2'h0;
	localparam logic [1:0]   RESP_SLVERR   = 2'h2;
endpackage : serial_port_pkg

// File: hw/serial_port_pins.sv
// Pin logic of one buffered serial port instance: shift clocks, frame syncs, data lines.
// Assumes pin inputs are asynchronous and an AXI4-Lite master with one access of each kind at a time.
//
// Behaviour
// RULE_01 - Receive shift clock pin selectable input or output, input after reset.
// RULE_02 - Receiver shifts incoming bits on the receive shift clock.
// RULE_03 - Far end drives received bits on the input-only receive data line.
// RULE_04 - Receive frame sync pin selectable input or output, input after reset.
// RULE_05 - Receive frame sync pulse starts reception of one word.
// RULE_06 - Transmitter shifts outgoing bits on the transmit shift clock.
// RULE_07 - Transmit shift clock pin selectable input or output, input after reset.
// RULE_08 - Transmit shift clock floats while the float control input is low.
// RULE_09 - Transmit data floats when idle, in chip reset, or float control low.
// RULE_10 - Transmit frame sync starts sending; selectable, input after reset, floats.
// RULE_11 - Output pins driven by internal generators, inputs use the external signal.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module serial_port_pins (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        chip_reset_n,
	input  wire logic        float_n,
	input  wire logic        rxShiftClockIn,
	output logic             rxShiftClockOut,
	output logic             rxShiftClockOe,
	input  wire logic        rxFrameSyncIn,
	output logic             rxFrameSyncOut,
	output logic             rxFrameSyncOe,
	input  wire logic        txShiftClockIn,
	output logic             txShiftClockOut,
	output logic             txShiftClockOe,
	input  wire logic        txFrameSyncIn,
	output logic             txFrameSyncOut,
	output logic             txFrameSyncOe,
	input  wire logic        serialRxLine,
	output logic             serialTxLine,
	output logic             serialTxOe,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	typedef struct packed {
		logic        awReady;
		logic        wReady;
		logic        arReady;
		logic [1:0]  chipSync;
		logic [1:0]  floatSync;
		logic [1:0]  rxClkSync;
		logic [1:0]  rxFsSync;
		logic [1:0]  txClkSync;
		logic [1:0]  txFsSync;
		logic [1:0]  rxDataSync;
		logic        rxClkPrev;
		logic        txClkPrev;
		logic [3:0]  control;
		logic [7:0]  clockDiv;
		logic [7:0]  divCount;
		logic        genClock;
		logic        genRxFs;
		logic        genTxFs;
		logic        txPending;
		logic        txActive;
		logic [4:0]  txCount;
		logic [15:0] txShift;
		logic [15:0] txHold;
		logic        txBit;
		logic        rxActive;
		logic [4:0]  rxCount;
		logic [15:0] rxShift;
		logic [15:0] rxData;
		logic        rxFull;
		logic        rxOverrun;
		logic        awHeld;
		logic [31:0] awAddr;
		logic        wHeld;
		logic [31:0] wData;
		logic        bValid;
		logic [1:0]  bResp;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		logic        rxClkOe;
		logic        rxFsOe;
		logic        txClkOe;
		logic        txFsOe;
		logic        txOe;
		logic        rxClkPin;
		logic        rxFsPin;
		logic        txClkPin;
		logic        txFsPin;
	} state_type;

	state_type state;
	state_type next_state;
	logic      rstnLocal;
	logic [1:0] rstPipe;

	// Reset release through two flops; only constants load asynchronously
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			rstPipe <= 2'h0;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstnLocal = rstPipe[1];
	function automatic logic falling(input logic prev, input logic now);
		return prev & ~now;
	endfunction : falling
	function automatic logic wstrbOk(input logic [3:0] strobes);
		return strobes[0];
	endfunction : wstrbOk
	logic rxClk, txClk, rxFs, txFs, rxEdgeFall, rxEdgeRise, txEdgeRise;
	logic readAddrOk;

	always_comb begin
		next_state = state;
		next_state.chipSync   = {state.chipSync[0], chip_reset_n};
		next_state.floatSync  = {state.floatSync[0], float_n};
		next_state.rxClkSync  = {state.rxClkSync[0], rxShiftClockIn};
		next_state.rxFsSync   = {state.rxFsSync[0], rxFrameSyncIn};
		next_state.txClkSync  = {state.txClkSync[0], txShiftClockIn};
		next_state.txFsSync   = {state.txFsSync[0], txFrameSyncIn};
		next_state.rxDataSync = {state.rxDataSync[0], serialRxLine}; // RULE_03
		// Internal bit clock and frame pulses for pins set as outputs
		if (state.divCount == 8'h00) begin
			next_state.divCount = state.clockDiv;
			next_state.genClock = ~state.genClock;
		end else begin
			next_state.divCount = state.divCount - 8'h01;
		end
		// Pick the external or the generated signal per pin
		rxClk = state.control[serial_port_pkg::CTL_RXCLK_OUT] ? state.genClock : state.rxClkSync[1]; // RULE_11
		txClk = state.control[serial_port_pkg::CTL_TXCLK_OUT] ? state.genClock : state.txClkSync[1]; // RULE_11
		rxFs  = state.control[serial_port_pkg::CTL_RXFS_OUT] ? state.genRxFs : state.rxFsSync[1];    // RULE_11
		txFs  = state.control[serial_port_pkg::CTL_TXFS_OUT] ? state.genTxFs : state.txFsSync[1];    // RULE_11
		next_state.rxClkPrev = rxClk;
		next_state.txClkPrev = txClk;
		rxEdgeFall = falling(state.rxClkPrev, rxClk);
		rxEdgeRise = falling(rxClk, state.rxClkPrev);
		txEdgeRise = falling(txClk, state.txClkPrev);
		// Generated frame syncs last one bit period, launched on a rising edge
		if (rxEdgeRise)
			next_state.genRxFs = ~state.rxActive & ~state.genRxFs;
		if (txEdgeRise)
			next_state.genTxFs = state.txPending & ~state.txActive & ~state.genTxFs;
		// Receiver: sample on falling edges, frame sync starts a word
		if (rxEdgeFall) begin // RULE_02
			if (!state.rxActive && rxFs) begin // RULE_05
				next_state.rxActive = 1'b1;
				next_state.rxCount  = 5'h00;
			end else if (state.rxActive) begin
				next_state.rxShift = {state.rxShift[14:0], state.rxDataSync[1]};
				if (state.rxCount == serial_port_pkg::WORD_LAST) begin
					next_state.rxActive  = 1'b0;
					next_state.rxData    = {state.rxShift[14:0], state.rxDataSync[1]};
					next_state.rxOverrun = state.rxOverrun | state.rxFull;
					next_state.rxFull    = 1'b1;
				end
				next_state.rxCount = state.rxCount + 5'h01;
			end
		end
		// Transmitter: change data on rising edges after the frame sync
		if (txEdgeRise) begin // RULE_06
			if (state.txActive) begin
				if (state.txCount == serial_port_pkg::WORD_LAST) begin
					next_state.txActive = 1'b0;
				end else begin
					next_state.txBit   = state.txShift[15];
					next_state.txShift = {state.txShift[14:0], 1'b0};
				end
				next_state.txCount = state.txCount + 5'h01;
			end else if (txFs && state.txPending) begin // RULE_10
				next_state.txActive  = 1'b1;
				next_state.txPending = 1'b0;
				next_state.txCount   = 5'h00;
				next_state.txBit     = state.txHold[15];
				next_state.txShift   = {state.txHold[14:0], 1'b0};
			end
		end
		// AXI4-Lite write: address and data accepted in either order
		if (awvalid && state.awReady) begin
			next_state.awHeld = 1'b1;
			next_state.awAddr = awaddr;
		end
		if (wvalid && state.wReady) begin
			next_state.wHeld = 1'b1;
			next_state.wData = wdata;
		end
		if (state.awHeld && state.wHeld && !state.bValid) begin
			next_state.awHeld = 1'b0;
			next_state.wHeld  = 1'b0;
			next_state.bValid = 1'b1;
			next_state.bResp  = serial_port_pkg::RESP_OKAY;
			unique case (state.awAddr)
				serial_port_pkg::OFS_CONTROL:
					if (wstrbOk(wstrb)) next_state.control = state.wData[3:0]; // RULE_01 RULE_04 RULE_07
				serial_port_pkg::OFS_TXDATA: begin
					next_state.txHold    = state.wData[15:0];
					next_state.txPending = 1'b1;
				end
				serial_port_pkg::OFS_CLKDIV:
					next_state.clockDiv = state.wData[7:0];
				serial_port_pkg::OFS_STATUS: ;
				serial_port_pkg::OFS_RXDATA: ;
				default:
					next_state.bResp = serial_port_pkg::RESP_SLVERR;
			endcase
		end
		if (state.bValid && bready)
			next_state.bValid = 1'b0;
		// AXI4-Lite read
		readAddrOk = 1'b1;
		if (arvalid && state.arReady) begin
			next_state.rValid = 1'b1;
			next_state.rData  = 32'h0000_0000;
			unique case (araddr)
				serial_port_pkg::OFS_CONTROL: next_state.rData[3:0] = state.control;
				serial_port_pkg::OFS_STATUS:
					next_state.rData[4:0] = {state.rxOverrun, state.rxFull, state.rxActive,
						state.txPending, state.txActive};
				serial_port_pkg::OFS_TXDATA:  next_state.rData[15:0] = state.txHold;
				serial_port_pkg::OFS_RXDATA: begin
					next_state.rData[15:0] = state.rxData;
					next_state.rxFull      = 1'b0;
					next_state.rxOverrun   = 1'b0;
				end
				serial_port_pkg::OFS_CLKDIV:  next_state.rData[7:0] = state.clockDiv;
				default:                      readAddrOk = 1'b0;
			endcase
			next_state.rResp = readAddrOk ? serial_port_pkg::RESP_OKAY : serial_port_pkg::RESP_SLVERR;
		end
		if (state.rValid && rready)
			next_state.rValid = 1'b0;
		// A word finishing in the same cycle as a data read still sets the flag
		if (rxEdgeFall && state.rxActive && state.rxCount == serial_port_pkg::WORD_LAST)
			next_state.rxFull = 1'b1;
		// Pin drivers; float control overrides the transmit enables only, not the receive clock and sync enables
		next_state.rxClkPin = state.genClock;
		next_state.txClkPin = state.genClock;
		next_state.rxFsPin  = state.genRxFs;
		next_state.txFsPin  = state.genTxFs;
		next_state.rxClkOe  = state.control[serial_port_pkg::CTL_RXCLK_OUT]; // RULE_01
		next_state.rxFsOe   = state.control[serial_port_pkg::CTL_RXFS_OUT];  // RULE_04
		next_state.txClkOe  = state.control[serial_port_pkg::CTL_TXCLK_OUT] & state.floatSync[1]; // RULE_07 RULE_08
		next_state.txFsOe   = state.control[serial_port_pkg::CTL_TXFS_OUT] & state.floatSync[1];  // RULE_10
		next_state.txOe     = state.txActive & state.chipSync[1] & state.floatSync[1]; // RULE_09
		next_state.awReady  = ~next_state.awHeld & ~next_state.bValid;
		next_state.wReady   = ~next_state.wHeld & ~next_state.bValid;
		next_state.arReady  = ~next_state.rValid;
		if (!state.chipSync[1]) begin
			next_state.control   = serial_port_pkg::CTL_RESET; // RULE_01 RULE_04 RULE_07 RULE_10
			next_state.txActive  = 1'b0;
			next_state.txPending = 1'b0;
			next_state.rxActive  = 1'b0;
			next_state.txOe      = 1'b0; // RULE_09
		end
	end

	always_ff @(posedge clock or negedge rstnLocal) begin
		if (!rstnLocal) begin
			state          <= '0;
			state.clockDiv <= serial_port_pkg::CLKDIV_RESET;
			state.control  <= serial_port_pkg::CTL_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign rxShiftClockOut = state.rxClkPin;
	assign rxShiftClockOe  = state.rxClkOe;
	assign rxFrameSyncOut  = state.rxFsPin;
	assign rxFrameSyncOe   = state.rxFsOe;
	assign txShiftClockOut = state.txClkPin;
	assign txShiftClockOe  = state.txClkOe;
	assign txFrameSyncOut  = state.txFsPin;
	assign txFrameSyncOe   = state.txFsOe;
	assign serialTxLine    = state.txBit;
	assign serialTxOe      = state.txOe;
	assign awready         = state.awReady;
	assign wready          = state.wReady;
	assign bvalid          = state.bValid;
	assign bresp           = state.bResp;
	assign arready         = state.arReady;
	assign rvalid          = state.rValid;
	assign rdata           = state.rData;
	assign rresp           = state.rResp;
endmodule : serial_port_pins

// File: bench/serial_port_pins_sva.sv
// Checker for serial_port_pins: pin directions, float control and transmit timing.
// Assumes pin inputs carry the resolved pin level.
`timescale 1ns/10ps
module serial_port_pins_sva (
	input wire logic clock,
	input wire logic rstn,
	input wire logic chip_reset_n,
	input wire logic float_n,
	input wire logic rxShiftClockOut,
	input wire logic rxShiftClockOe,
	input wire logic rxFrameSyncOe,
	input wire logic txShiftClockIn,
	input wire logic txShiftClockOut,
	input wire logic txShiftClockOe,
	input wire logic txFrameSyncIn,
	input wire logic txFrameSyncOut,
	input wire logic txFrameSyncOe,
	input wire logic serialTxLine,
	input wire logic serialTxOe
);
	logic [3:0] fsAge;
	logic [3:0] clkAge;
	logic       clkQ;
	logic       txClk;
	logic       txFs;
	assign txClk = txShiftClockOe ? txShiftClockOut : txShiftClockIn;
	assign txFs = txFrameSyncOe ? txFrameSyncOut : txFrameSyncIn;
	// Ages in cycles since frame sync high and since the last transmit clock edge
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fsAge <= 4'hf;
			clkAge <= 4'hf;
			clkQ <= 1'b0;
		end else begin
			fsAge <= txFs ? 4'h0 : fsAge + 4'(fsAge != 4'hf);
			clkAge <= (txClk != clkQ) ? 4'h0 : clkAge + 4'(clkAge != 4'hf);
			clkQ <= txClk;
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	reset_dir_a: assert property ($rose(rstn) |-> !rxShiftClockOe && !rxFrameSyncOe && !txShiftClockOe && !txFrameSyncOe)
		else $error("pin driven right after reset");
	chip_dir_a: assert property (!chip_reset_n [*6] |-> !rxShiftClockOe && !rxFrameSyncOe && !txShiftClockOe && !txFrameSyncOe)
		else $error("pin driven in chip reset");
	chip_tx_a: assert property (!chip_reset_n [*6] |-> !serialTxOe)
		else $error("transmit data driven in chip reset");
	float_tx_a: assert property (!float_n [*6] |-> !txShiftClockOe && !txFrameSyncOe && !serialTxOe)
		else $error("transmit pin driven while floated");
	rx_gen_a: assert property ($rose(rxShiftClockOe) |-> ##[1:600] ($changed(rxShiftClockOut) || !rxShiftClockOe))
		else $error("receive clock output not generated");
	tx_gen_a: assert property ($rose(txShiftClockOe) |-> ##[1:600] ($changed(txShiftClockOut) || !txShiftClockOe))
		else $error("transmit clock output not generated");
	tx_start_a: assert property ($rose(serialTxOe) |-> fsAge < 4'hc)
		else $error("transmit began without frame sync");
	tx_shift_a: assert property (serialTxOe && $changed(serialTxLine) |-> clkAge < 4'h8)
		else $error("transmit bit changed away from clock edge");
endmodule : serial_port_pins_sva

bind serial_port_pins serial_port_pins_sva i_serial_port_pins_sva (.clock, .rstn, .chip_reset_n, .float_n,
	.rxShiftClockOut, .rxShiftClockOe, .rxFrameSyncOe, .txShiftClockIn, .txShiftClockOut, .txShiftClockOe,
	.txFrameSyncIn, .txFrameSyncOut, .txFrameSyncOe, .serialTxLine, .serialTxOe);

// File: bench/serial_far_end.sv
// Far-end codec model: framed bit clock, frame sync and receive data; captures transmit data.
// Assumes the bench routes its outputs to the receive and transmit pin inputs.
`timescale 1ns/10ps
module serial_far_end (
	output logic        farClk,
	output logic        farSync,
	output logic        farData,
	input  wire logic   txLine,
	input  wire logic   txOe,
	output logic [15:0] heard,
	output logic        heardOe
);
	initial begin
		farClk = 1'b0;
		farSync = 1'b0;
		farData = 1'b0;
	end
	// Clock stands still between frames; outside the word the data line toggles
	// Sync and data change midway between edges so both edges see them settled
	task automatic frame(input logic [15:0] word);
		heardOe = 1'b1;
		for (int k = 0; k < 18; k++) begin
			farSync = (k == 0);
			farData = (k >= 1 && k <= 16) ? word[16 - k] : ~farData;
			#31.25 farClk = 1'b1;
			#62.5 if (k < 16) begin
				heard = {heard[14:0], txLine};
				heardOe = heardOe & txOe;
			end
			farClk = 1'b0;
			#31.25;
		end
	endtask : frame
endmodule : serial_far_end

// File: bench/buffered_serial_port_pins_tb.sv
// Self-checking bench for serial_port_pins: registers, directions, float, chip reset, framed traffic.
// Assumes the far-end model drives each pin the block leaves as input.
`timescale 1ns/10ps
module buffered_serial_port_pins_tb;
	logic        clock, rstn, chipRstN, floatN, farClk, farSync, farData, heardOe, level;
	logic        rxClkOut, rxClkOe, rxFsOut, rxFsOe, txClkOut, txClkOe, txFsOut, txFsOe, txLine, txOe;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata, seed, got, divModel;
	logic [15:0] heard;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic [15:0] rxModel[$];
	int          numErrors = 0;
	int          totalChecks = 0;
	int          cycles = 0;
	int          half;
	serial_port_pins i_serial_port_pins (.clock, .rstn, .chip_reset_n(chipRstN), .float_n(floatN),
		.rxShiftClockIn(rxClkOe ? rxClkOut : farClk), .rxShiftClockOut(rxClkOut), .rxShiftClockOe(rxClkOe),
		.rxFrameSyncIn(rxFsOe ? rxFsOut : farSync), .rxFrameSyncOut(rxFsOut), .rxFrameSyncOe(rxFsOe),
		.txShiftClockIn(txClkOe ? txClkOut : farClk), .txShiftClockOut(txClkOut), .txShiftClockOe(txClkOe),
		.txFrameSyncIn(txFsOe ? txFsOut : farSync), .txFrameSyncOut(txFsOut), .txFrameSyncOe(txFsOe),
		.serialRxLine(farData), .serialTxLine(txLine), .serialTxOe(txOe), .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);
	serial_far_end i_serial_far_end (.farClk, .farSync, .farData, .txLine, .txOe, .heard, .heardOe);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			numErrors++;
			conclude();
		end
	end
	task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask : axiWrite
	task automatic axiRead(input logic [31:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axiRead
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, wstrb, araddr} = '0;
		{chipRstN, floatN} = 2'h3;
		seed = 32'h3ecafb5c;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		check("enables", 32'({rxClkOe, rxFsOe, txClkOe, txFsOe, txOe}), 32'h0);
		axiRead(serial_port_pkg::OFS_CONTROL);
		check("control", got, 32'(serial_port_pkg::CTL_RESET));
		axiRead(32'h0000_0014);
		check("unmapped", 32'(resp), 32'(serial_port_pkg::RESP_SLVERR));
		$display("reset test done");
		for (int n = 0; n < 3; n++) begin
			seed = xorshift(seed);
			rxModel.push_back(seed[31:16]);
			axiWrite(serial_port_pkg::OFS_TXDATA, {16'h0, seed[15:0]}, 4'hf);
			check("write resp", 32'(resp), 32'(serial_port_pkg::RESP_OKAY));
			i_serial_far_end.frame(seed[31:16]);
			repeat (8) @(posedge clock);
			check("tx word", 32'(heard), {16'h0, seed[15:0]});
			check("tx driven", 32'(heardOe), 32'h1);
			check("tx idle", 32'(txOe), 32'h0);
			axiRead(serial_port_pkg::OFS_RXDATA);
			check("rx word", got, {16'h0, rxModel.pop_front()});
		end
		axiRead(serial_port_pkg::OFS_STATUS);
		check("status idle", got, 32'h0);
		$display("traffic test done");
		seed = xorshift(seed);
		divModel = {29'h0, seed[2:0]};
		axiWrite(serial_port_pkg::OFS_CLKDIV, divModel, 4'hf);
		axiWrite(serial_port_pkg::OFS_CONTROL, 32'h0000_000f, 4'hf);
		axiWrite(serial_port_pkg::OFS_CONTROL, 32'h0, 4'h0);
		repeat (4) @(posedge clock);
		check("outputs", 32'({rxClkOe, rxFsOe, txClkOe, txFsOe}), 32'hf);
		check("tx clock out", 32'(txClkOut), 32'(rxClkOut));
		level = rxClkOut;
		while (rxClkOut === level) @(posedge clock);
		level = rxClkOut;
		half = 0;
		while (rxClkOut === level) begin
			@(posedge clock);
			half++;
		end
		check("half period", 32'(half), divModel + 32'h1);
		$display("direction test done");
		floatN <= 1'b0;
		repeat (6) @(posedge clock);
		check("floated", 32'({rxClkOe, rxFsOe, txClkOe, txFsOe, txOe}), 32'h18);
		floatN <= 1'b1;
		repeat (6) @(posedge clock);
		chipRstN <= 1'b0;
		repeat (8) @(posedge clock);
		check("chip reset", 32'({rxClkOe, rxFsOe, txClkOe, txFsOe, txOe}), 32'h0);
		chipRstN <= 1'b1;
		axiRead(serial_port_pkg::OFS_CONTROL);
		check("control cleared", got, 32'h0);
		$display("float and chip reset test done");
		conclude();
	end
endmodule : buffered_serial_port_pins_tb
